/* File: verilog/anar_pkg.sv */
package anar_pkg;

    // ==========================================================
    // register indices (word addresses on the register port)
    localparam logic [15:0] ADV_MIDDLE_ADDR      = 16'h0203;
    localparam logic [15:0] ADV_UPPER_ADDR       = 16'h0204;
    localparam logic [15:0] PARTNER_LOWER_ADDR   = 16'h0205;
    localparam logic [15:0] PARTNER_MIDDLE_ADDR  = 16'h0206;
    localparam logic [15:0] PARTNER_UPPER_ADDR   = 16'h0207;
    localparam logic [15:0] ADV_LOWER_ADDR       = 16'h0202;
    localparam logic [15:0] TX_LEVEL_ADDR        = 16'h0210;

    // ==========================================================
    // reset values
    localparam logic [15:0] ADV_MIDDLE_RST       = 16'h4000;
    localparam logic [15:0] ADV_UPPER_RST        = 16'h0000;
    localparam logic [15:0] PARTNER_LOWER_RST    = 16'h0000;
    localparam logic [15:0] ADV_LOWER_RST        = 16'h0001;

    // ==========================================================
    // field positions
    localparam int LONG_REACH_BIT    = 14;
    localparam int LEADER_ROLE_BIT   = 4;
    localparam int HS_CAPABLE_BIT    = 13;
    localparam int HS_REQUEST_BIT    = 12;
    localparam int NEXT_PAGE_BIT     = 15;
    localparam int ACK_BIT           = 14;
    localparam int REMOTE_FAULT_BIT  = 13;
    localparam int ROLE_FORCED_BIT   = 12;
    localparam int PAUSE_HI_BIT      = 11;
    localparam int PAUSE_LO_BIT      = 10;
    localparam int SELECTOR_HI_BIT   = 4;
    localparam int SELECTOR_LO_BIT   = 0;
    localparam int NONCE_ROLE_BIT    = 4;

    // ==========================================================
    // strap load timing, in edges after reset release
    localparam logic [1:0]  STRAP_LOAD_CNT       = 2'h2;
    localparam logic [1:0]  STRAP_CNT_LAST       = 2'h3;

    // ==========================================================
    // writable and readable masks
    localparam logic [15:0] ADV_MIDDLE_MASK      = 16'h4010;
    localparam logic [15:0] ADV_UPPER_MASK       = 16'h3000;
    localparam logic [15:0] PARTNER_LOWER_MASK   = 16'hFC1F;
    localparam logic [15:0] ADV_LOWER_WR_MASK    = 16'hBC00;
    localparam logic [15:0] PARTNER_MIDDLE_MASK  = 16'h40F0;
    localparam logic [15:0] PARTNER_UPPER_MASK   = 16'h7000;

endpackage

/* File: verilog/anar_regs.sv */
`timescale 1ns/1ps
// Function
// - long-reach ability, bit 14 of middle advertisement word, read/write, resets to 1
// - leader role bit 4 of middle word, 1 leader, reset from strap pin
// - advertised role is sent in bit 4 of the transmitted nonce
// - high-swing capable bit 13 of upper word, read/write, strap reset
// - high-swing request bit 12 of upper word, read/write, strap reset
// - either side not capable resolves to the low 1.0 V level
// - both capable and any request resolves to the high 2.4 V level
// - reading partner lower word snapshots partner middle and upper words
// - partner lower bit 15 reports partner next page request
// - partner lower bit 14 reports received acknowledge
// - partner lower bit 13 reports partner remote fault
// - partner lower bit 12 reports partner role forced or preferred
// - partner lower bits 11:10 report partner pause ability
// - partner lower bits 4:0 hold received selector
// - middle resets to 0x4000, upper and partner lower to zero
// - lower advertisement bit 12 marks the role forced when set
module anar_regs #(
    parameter int ADDR_W = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    input  wire logic              strap_leader,
    input  wire logic              strap_high_swing,
    input  wire logic [47:0]       partner_page,
    input  wire logic              partner_page_valid,
    output logic      [47:0]       local_page,
    output logic      [7:0]        nonce_out,
    input  wire logic [7:0]        nonce_seed,
    output logic                   tx_level_high
);

    // ==========================================================
    // parameter checks
    // the decode compares a full 16-bit word address, so a narrower bus cannot reach the map
    generate
        if (ADDR_W < 16) begin : g_bad_width
            $error("anar_regs: ADDR_W must be at least 16");
        end
    endgenerate

    // the middle and upper reset words must not set a bit that the write masks keep reserved; the lower one must stay clear of its writable bits
    generate
        if ((anar_pkg::ADV_MIDDLE_RST & ~anar_pkg::ADV_MIDDLE_MASK) != 16'h0000) begin : g_bad_mid
            $error("anar_regs: middle reset value sets a reserved bit");
        end
        if ((anar_pkg::ADV_UPPER_RST & ~anar_pkg::ADV_UPPER_MASK) != 16'h0000) begin : g_bad_up
            $error("anar_regs: upper reset value sets a reserved bit");
        end
        if ((anar_pkg::ADV_LOWER_RST & anar_pkg::ADV_LOWER_WR_MASK) != 16'h0000) begin : g_bad_low
            $error("anar_regs: lower reset value overlaps the writable bits");
        end
    endgenerate

    // field positions must sit inside the masks, or writes and captures would drop them
    generate
        if (anar_pkg::ADV_MIDDLE_MASK[anar_pkg::LONG_REACH_BIT] != 1'b1) begin : g_bad_lr
            $error("anar_regs: long-reach bit outside the middle mask");
        end
        if (anar_pkg::ADV_MIDDLE_MASK[anar_pkg::LEADER_ROLE_BIT] != 1'b1) begin : g_bad_role
            $error("anar_regs: role bit outside the middle mask");
        end
        if (anar_pkg::ADV_UPPER_MASK[anar_pkg::HS_CAPABLE_BIT] != 1'b1) begin : g_bad_cap
            $error("anar_regs: capable bit outside the upper mask");
        end
        if (anar_pkg::ADV_UPPER_MASK[anar_pkg::HS_REQUEST_BIT] != 1'b1) begin : g_bad_req
            $error("anar_regs: request bit outside the upper mask");
        end
        if (anar_pkg::ADV_LOWER_WR_MASK[anar_pkg::ROLE_FORCED_BIT] != 1'b1) begin : g_bad_forced
            $error("anar_regs: role-forced bit outside the lower mask");
        end
        if (anar_pkg::PARTNER_UPPER_MASK[anar_pkg::HS_CAPABLE_BIT] != 1'b1) begin : g_bad_lp_cap
            $error("anar_regs: partner capable bit is masked away");
        end
        if (anar_pkg::PARTNER_UPPER_MASK[anar_pkg::HS_REQUEST_BIT] != 1'b1) begin : g_bad_lp_req
            $error("anar_regs: partner request bit is masked away");
        end
        if (anar_pkg::NONCE_ROLE_BIT != 4) begin : g_bad_nonce
            $error("anar_regs: nonce assembly expects the role at bit 4");
        end
    endgenerate

    // ==========================================================
    // strap synchronisers; first stage feeds only the second
    logic [1:0] strap_leader_s_r;
    logic [1:0] strap_hs_s_r;
    logic       strap_load_r;

    // no reset here: the chain flushes long before the straps are loaded
    always_ff @(posedge ref_clk) begin
        strap_leader_s_r <= {strap_leader_s_r[0], strap_leader};
    end

    always_ff @(posedge ref_clk) begin
        strap_hs_s_r <= {strap_hs_s_r[0], strap_high_swing};
    end

    // ==========================================================
    // strap load pulse
    // straps are loaded a few cycles after release, once the sync has settled
    logic [1:0] strap_cnt_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_cnt_r <= 2'h0;
        end else if (strap_cnt_r != anar_pkg::STRAP_CNT_LAST) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end

    // a single pulse, so software writes made later are never overwritten
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_load_r <= 1'b0;
        end else begin
            strap_load_r <= (strap_cnt_r == anar_pkg::STRAP_LOAD_CNT);
        end
    end

    // ==========================================================
    // address decode
    // only the low 16 address bits take part; a wider bus aliases the map upward
    logic [15:0] addr16;
    logic        hit_adv_mid;
    logic        hit_adv_up;
    logic        hit_adv_low;
    logic        hit_lp_low;

    assign addr16      = reg_addr[15:0];
    assign hit_adv_mid = (addr16 == anar_pkg::ADV_MIDDLE_ADDR);
    assign hit_adv_up  = (addr16 == anar_pkg::ADV_UPPER_ADDR);
    assign hit_adv_low = (addr16 == anar_pkg::ADV_LOWER_ADDR);
    assign hit_lp_low  = (addr16 == anar_pkg::PARTNER_LOWER_ADDR);

    // ==========================================================
    // advertisement words
    logic [15:0] adv_mid_r;
    logic [15:0] adv_up_r;
    logic [15:0] adv_low_r;

    // a strap load in the same cycle as a write wins; it only happens once, after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adv_mid_r <= anar_pkg::ADV_MIDDLE_RST;
        end else if (strap_load_r) begin
            adv_mid_r[anar_pkg::LEADER_ROLE_BIT] <= strap_leader_s_r[1];
        end else if (reg_wr && hit_adv_mid) begin
            adv_mid_r <= reg_wdata & anar_pkg::ADV_MIDDLE_MASK;
        end
    end

    // one strap sets both bits, so a strapped part also asks for the high level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adv_up_r <= anar_pkg::ADV_UPPER_RST;
        end else if (strap_load_r) begin
            adv_up_r[anar_pkg::HS_CAPABLE_BIT] <= strap_hs_s_r[1];
            adv_up_r[anar_pkg::HS_REQUEST_BIT] <= strap_hs_s_r[1];
        end else if (reg_wr && hit_adv_up) begin
            adv_up_r <= reg_wdata & anar_pkg::ADV_UPPER_MASK;
        end
    end

    // lower word kept here for the role-forced bit; selector is fixed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adv_low_r <= anar_pkg::ADV_LOWER_RST;
        end else if (reg_wr && hit_adv_low) begin
            adv_low_r <= (reg_wdata & anar_pkg::ADV_LOWER_WR_MASK)
                         | anar_pkg::ADV_LOWER_RST;
        end
    end

    // ==========================================================
    // partner page capture and snapshot
    logic [15:0] lp_low_r;
    logic [15:0] lp_mid_live_r;
    logic [15:0] lp_up_live_r;
    logic [15:0] lp_mid_snap_r;
    logic [15:0] lp_up_snap_r;

    // reserved partner bits are masked here, so every later path reads them as zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lp_low_r <= anar_pkg::PARTNER_LOWER_RST;
        end else if (partner_page_valid) begin
            lp_low_r <= partner_page[15:0]
                        & anar_pkg::PARTNER_LOWER_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lp_mid_live_r <= 16'h0000;
        end else if (partner_page_valid) begin
            lp_mid_live_r <= partner_page[31:16] & anar_pkg::PARTNER_MIDDLE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lp_up_live_r <= 16'h0000;
        end else if (partner_page_valid) begin
            lp_up_live_r <= partner_page[47:32] & anar_pkg::PARTNER_UPPER_MASK;
        end
    end

    // snapshot taken from the live words, so a page landing in the same
    // cycle is not mixed half old, half new
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lp_mid_snap_r <= 16'h0000;
        end else if (reg_rd && hit_lp_low) begin
            lp_mid_snap_r <= lp_mid_live_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lp_up_snap_r <= 16'h0000;
        end else if (reg_rd && hit_lp_low) begin
            lp_up_snap_r <= lp_up_live_r;
        end
    end

    // ==========================================================
    // transmit level resolution
    // resolved from the live partner word, not the snapshot, so reading the
    // partner words never moves the level
    logic hs_both_capable;
    logic hs_any_request;

    assign hs_both_capable = adv_up_r[anar_pkg::HS_CAPABLE_BIT]
                             & lp_up_live_r[anar_pkg::HS_CAPABLE_BIT];
    assign hs_any_request  = adv_up_r[anar_pkg::HS_REQUEST_BIT]
                             | lp_up_live_r[anar_pkg::HS_REQUEST_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_level_high <= 1'b0;
        end else if (!hs_both_capable) begin
            tx_level_high <= 1'b0;
        end else begin
            tx_level_high <= hs_any_request;
        end
    end

    // ==========================================================
    // outgoing base page and nonce
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            local_page <= 48'h0000_0000_0000;
        end else begin
            local_page <= {adv_up_r, adv_mid_r, adv_low_r};
        end
    end

    // only the role bit of the nonce is ours; the rest passes from the seed unchanged
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nonce_out <= 8'h00;
        end else begin
            nonce_out <= {nonce_seed[7:5], adv_mid_r[anar_pkg::LEADER_ROLE_BIT],
                          nonce_seed[3:0]};
        end
    end

    // ==========================================================
    // read port; data one cycle after the strobe, zero otherwise
    logic [15:0] rd_nxt;

    always_comb begin
        rd_nxt = 16'h0000;
        unique case (addr16)
            anar_pkg::ADV_LOWER_ADDR:      rd_nxt = adv_low_r;
            anar_pkg::ADV_MIDDLE_ADDR:     rd_nxt = adv_mid_r;
            anar_pkg::ADV_UPPER_ADDR:      rd_nxt = adv_up_r;
            anar_pkg::PARTNER_LOWER_ADDR:  rd_nxt = lp_low_r;
            anar_pkg::PARTNER_MIDDLE_ADDR: rd_nxt = lp_mid_snap_r;
            anar_pkg::PARTNER_UPPER_ADDR:  rd_nxt = lp_up_snap_r;
            anar_pkg::TX_LEVEL_ADDR:       rd_nxt = {15'h0, tx_level_high};
            default:                       rd_nxt = 16'h0000;
        endcase
    end

    // zero outside the slot, so a stale word never looks like a fresh read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_nxt;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule

/* File: tb/anar_regs_assertions.sv */
`timescale 1ns/1ps
// ====================================
// port checker
module anar_regs_assertions #(
    parameter int ADDR_W = 16
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    input wire logic [47:0]       partner_page,
    input wire logic              partner_page_valid,
    input wire logic [47:0]       local_page,
    input wire logic [7:0]        nonce_out,
    input wire logic              tx_level_high
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [2:0]  age_r;
    logic [47:0] live_r;
    logic [31:0] snap_r;
    // age gate keeps checks off the cleared outputs and the strap load
    always_ff @(posedge ref_clk) begin
        if (rst) age_r <= 3'h0;
        else if (age_r != 3'h7) age_r <= age_r + 3'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) live_r <= '0;
        else if (partner_page_valid) live_r <= partner_page & 48'h7000_40F0_FC1F;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) snap_r <= '0;
        else if (reg_rd && reg_addr == 16'h0205) snap_r <= live_r[47:16];
    end
    sequence rd_of(logic [15:0] a);
        reg_rd && reg_addr == a;
    endsequence
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    a_lower_read: assert property (rd_of(16'h0205) |=> reg_rdata == $past(live_r[15:0]))
        else $error("partner lower word wrong");
    a_snap_mid: assert property (rd_of(16'h0206) |=> reg_rdata == $past(snap_r[15:0]))
        else $error("partner middle not the snapshot");
    a_snap_up: assert property (rd_of(16'h0207) |=> reg_rdata == $past(snap_r[31:16]))
        else $error("partner upper not the snapshot");
    a_level_resolve: assert property (partner_page_valid ##2 age_r == 3'h7 |->
        tx_level_high == ($past(live_r[45]) & local_page[45]
        & ($past(live_r[44]) | local_page[44])))
        else $error("transmit level misresolved");
    a_nonce_role: assert property (age_r == 3'h7 |-> nonce_out[4] == local_page[20])
        else $error("nonce role bit differs");
    a_mid_rsvd: assert property ((local_page[31:16] & 16'hBFEF) == 16'h0000)
        else $error("middle reserved bit set");
    a_up_rsvd: assert property ((local_page[47:32] & 16'hCFFF) == 16'h0000)
        else $error("upper reserved bit set");
    a_lower_fixed: assert property (age_r == 3'h7 |-> local_page[9:0] == 10'h001)
        else $error("lower selector or reserved wrong");
endmodule

bind anar_regs anar_regs_assertions #(.ADDR_W(ADDR_W)) chk_u (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .partner_page(partner_page), .partner_page_valid(partner_page_valid),
    .local_page(local_page), .nonce_out(nonce_out), .tx_level_high(tx_level_high));

/* File: tb/anar_link_partner.sv */
`timescale 1ns/1ps
// ====================================
// far phy: sends base pages, resolves level
module anar_link_partner (
    input  wire logic        ref_clk,
    input  wire logic [47:0] local_page,
    output logic      [47:0] partner_page,
    output logic             partner_page_valid,
    output logic             level_high
);
    logic [47:0] sent_r = '0;
    initial begin
        partner_page = '0;
        partner_page_valid = 1'b0;
    end
    assign level_high = sent_r[45] & local_page[45] & (sent_r[44] | local_page[44]);
    task automatic send(input logic [47:0] page);
        @(posedge ref_clk);
        partner_page <= page;
        partner_page_valid <= 1'b1;
        sent_r <= page;
        @(posedge ref_clk);
        // inverted once released so a stale word is never mistaken for data
        partner_page <= ~page;
        partner_page_valid <= 1'b0;
    endtask
endmodule

/* File: tb/test_anar_regs.sv */
`timescale 1ns/1ps
module test_anar_regs;
    typedef struct {logic [15:0] a; logic [15:0] w; logic [15:0] e;} anar_row_t;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        s_lead = 1'b1;
    logic        s_hs = 1'b0;
    logic [7:0]  seed = 8'hEF;
    logic [15:0] rdata;
    logic [47:0] ppage;
    logic        pval;
    logic [47:0] lpage;
    logic [7:0]  nonce;
    logic        lvl;
    logic        plvl;
    int          error_cnt = 0;
    int          tests_run = 0;
    anar_row_t   rows [8] = '{'{16'h0203, 16'hFFFF, 16'h4010}, '{16'h0203, 16'h0000, 16'h0000},
        '{16'h0204, 16'hFFFF, 16'h3000}, '{16'h0204, 16'h1000, 16'h1000},
        '{16'h0205, 16'hFFFF, 16'h0000}, '{16'h0300, 16'hFFFF, 16'h0000},
        '{16'h0202, 16'hFFFF, 16'hBC01}, '{16'h0202, 16'h0000, 16'h0001}};
    always #10 ref_clk = ~ref_clk;
    anar_regs dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .strap_leader(s_lead),
        .strap_high_swing(s_hs), .partner_page(ppage), .partner_page_valid(pval),
        .local_page(lpage), .nonce_out(nonce), .nonce_seed(seed), .tx_level_high(lvl));
    anar_link_partner far_u (.ref_clk(ref_clk), .local_page(lpage), .partner_page(ppage),
        .partner_page_valid(pval), .level_high(plvl));
    // ====================================
    // bus tasks and compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge ref_clk);
        error_cnt++;
        conclude();
    end
    // ====================================
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rchk(16'h0203, 16'h4010);
        rchk(16'h0204, 16'h0000);
        rchk(16'h0205, 16'h0000);
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].w);
            rchk(rows[i].a, rows[i].e);
        end
        for (int r = 0; r < 2; r++) begin
            wreg(16'h0203, {11'h000, r[0], 4'h0});
            repeat (3) @(posedge ref_clk);
            #1 chk({8'h00, nonce}, {8'h00, 3'h7, r[0], 4'hF});
        end
        for (int c = 0; c < 16; c++) begin
            wreg(16'h0204, {2'h0, c[1:0], 12'h000});
            far_u.send({2'h0, c[3:2], 12'h000, 32'hFFFF_FFFF});
            repeat (3) @(posedge ref_clk);
            #1 chk({15'h0, lvl}, {15'h0, c[1] & c[3] & (c[0] | c[2])});
            chk({15'h0, lvl}, {15'h0, plvl});
        end
        rchk(16'h0210, 16'h0001);
        rchk(16'h0205, 16'hFC1F);
        far_u.send(48'h0000_0000_0401);
        rchk(16'h0206, 16'h40F0);
        rchk(16'h0207, 16'h3000);
        rchk(16'h0205, 16'h0401);
        rchk(16'h0206, 16'h0000);
        @(posedge ref_clk);
        s_lead <= 1'b0;
        s_hs <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rchk(16'h0203, 16'h4000);
        rchk(16'h0204, 16'h3000);
        conclude();
    end
endmodule
